// *** src/spif_frame.v ***
`timescale 1ns/1ps
`default_nettype none

`include "spif_regs.vh"

// Overview of operation
// - Acts only as SPI slave on chip select, clock, data in and data out.
// - Supports clock modes 0 and 3 only.
// - Samples incoming data on rising clock edge, changes outgoing data on falling edge.
// - Bytes on both data lines go most significant bit first.
// - Modes 0 and 3 differ only in idle clock level; mode 0 idles low.
// - Frame is 16-bit offset, then 8-bit control, then one or more data bytes.
// - Offset arrives high-order bit first, upper byte before lower byte.
// - Control bits 7:3 select block, bit 2 is read/write, bits 1:0 mode.
// - Block 0 is common; 4n+1, 4n+2, 4n+3 are socket regs, tx, rx buffers.
// - Data phase is any count of bytes, or exactly one, two or four.
// - Multi-byte access starts at the offset and increments by one per byte.
// - Chip select fall starts address phase; rise ends the data phase.
// - Read/write bit clear means read, set means write.
// - Mode field 00 selects variable length bounded by chip select.
module spif_frame (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        nrst,
    // SPI pins to and from the host
    input  wire        chip_select_n,
    input  wire        spi_sclk,
    input  wire        spi_mosi,
    output reg         spi_miso_o,
    output reg         spi_miso_oe_n,
    // Byte access to the internal stores
    output reg  [15:0] mem_addr,
    output reg  [4:0]  mem_block,
    output reg         mem_wr,
    output reg  [7:0]  mem_wdata,
    output reg         mem_rd,
    input  wire [7:0]  mem_rdata,
    // Decoded block of the current frame
    output reg         blk_common,
    output reg         blk_socket_reg,
    output reg         blk_tx_buf,
    output reg         blk_rx_buf,
    output reg         blk_reserved,
    output reg  [2:0]  blk_socket,
    // Frame status
    output wire        frame_active,
    output wire        data_phase,
    output reg         fixed_length_mode
);

    localparam ST_ADDR_HI = 2'h0;
    localparam ST_ADDR_LO = 2'h1;
    localparam ST_CTRL    = 2'h2;
    localparam ST_DATA    = 2'h3;

    wire [2:0] pins_s;
    wire       cs_n_s;
    wire       sclk_s;
    wire       mosi_s;

    reg        sclk_d_r;
    reg        cs_n_d_r;
    reg  [1:0] state_r;
    reg  [2:0] bit_cnt_r;
    reg  [6:0] rx_sh_r;
    reg  [7:0] tx_sh_r;
    reg  [15:0] addr_r;
    reg        rwb_r;
    reg  [1:0] om_r;
    reg  [2:0] byte_cnt_r;
    reg        rd_dly_r;

    wire       sclk_rise;
    wire       sclk_fall;
    wire       cs_fall;
    wire       byte_done;
    wire [7:0] rx_byte;
    reg  [2:0] fix_len;

    // Every pin crosses into clk_sys before use; the link clock is just sampled
    // Select resets to its idle high level, so reset neither fakes a select edge nor drives data out
    spif_sync #(
        .WIDTH   (3),
        .RST_VAL (3'h4)
    ) u_sync (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .async_in ({chip_select_n, spi_sclk, spi_mosi}),
        .sync_out (pins_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // Mode 0 and 3 both sample on rise and drive on fall, so idle level is ignored
    assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_r;
    assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_r;
    assign cs_fall   = cs_n_d_r & ~cs_n_s;
    assign byte_done = sclk_rise & (bit_cnt_r == 3'h7);
    assign rx_byte   = {rx_sh_r, mosi_s};

    assign frame_active = ~cs_n_s;
    assign data_phase   = (state_r == ST_DATA);

    always @*
    begin
        case (om_r)
            `SPIF_OM_FIX1: fix_len = `SPIF_LEN_1;
            `SPIF_OM_FIX2: fix_len = `SPIF_LEN_2;
            `SPIF_OM_FIX4: fix_len = `SPIF_LEN_4;
            default:       fix_len = `SPIF_LEN_1;
        endcase
    end

    // Frame sequencer
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_d_r          <= 1'b0;
            cs_n_d_r          <= 1'b1;
            state_r           <= ST_ADDR_HI;
            bit_cnt_r         <= 3'h0;
            rx_sh_r           <= 7'h00;
            addr_r            <= `SPIF_ADDR_RST;
            rwb_r             <= `SPIF_RWB_READ;
            om_r              <= `SPIF_OM_VAR;
            byte_cnt_r        <= 3'h0;
            fixed_length_mode <= 1'b0;
            mem_addr          <= `SPIF_ADDR_RST;
            mem_block         <= 5'h00;
            mem_wr            <= 1'b0;
            mem_wdata         <= 8'h00;
            mem_rd            <= 1'b0;
        end
        else
        begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
            mem_wr   <= 1'b0;
            mem_rd   <= 1'b0;
            if (cs_n_s || cs_fall)
            begin
                // Deselect ends any frame; the select edge starts a fresh one
                state_r    <= ST_ADDR_HI;
                bit_cnt_r  <= 3'h0;
                byte_cnt_r <= 3'h0;
            end
            else if (sclk_rise)
            begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                rx_sh_r   <= rx_byte[6:0];
                if (byte_done)
                begin
                    case (state_r)
                        ST_ADDR_HI:
                        begin
                            addr_r[15:8] <= rx_byte;
                            state_r      <= ST_ADDR_LO;
                        end
                        ST_ADDR_LO:
                        begin
                            addr_r[7:0] <= rx_byte;
                            state_r     <= ST_CTRL;
                        end
                        ST_CTRL:
                        begin
                            mem_block         <= rx_byte[`SPIF_BSB_HI:`SPIF_BSB_LO];
                            rwb_r             <= rx_byte[`SPIF_RWB_BIT];
                            om_r              <= rx_byte[`SPIF_OM_HI:`SPIF_OM_LO];
                            fixed_length_mode <= (rx_byte[`SPIF_OM_HI:`SPIF_OM_LO] != `SPIF_OM_VAR);
                            byte_cnt_r        <= 3'h0;
                            state_r           <= ST_DATA;
                            mem_addr          <= addr_r;
                            // Prefetch the first byte so it is ready by the next falling edge
                            mem_rd <= (rx_byte[`SPIF_RWB_BIT] == `SPIF_RWB_READ);
                        end
                        ST_DATA:
                        begin
                            addr_r <= addr_r + 16'h0001;
                            if (rwb_r == `SPIF_RWB_WRITE)
                            begin
                                mem_addr  <= addr_r;
                                mem_wdata <= rx_byte;
                                mem_wr    <= 1'b1;
                            end
                            else
                            begin
                                mem_addr <= addr_r + 16'h0001;
                                mem_rd   <= 1'b1;
                            end
                            if (om_r != `SPIF_OM_VAR)
                            begin
                                if (byte_cnt_r + 3'h1 == fix_len)
                                begin
                                    // Chip select need not rise here, so the count closes the frame
                                    state_r    <= ST_ADDR_HI;
                                    byte_cnt_r <= 3'h0;
                                    mem_rd     <= 1'b0;
                                end
                                else
                                begin
                                    byte_cnt_r <= byte_cnt_r + 3'h1;
                                end
                            end
                        end
                        default:
                        begin
                            state_r <= ST_ADDR_HI;
                        end
                    endcase
                end
            end
        end
    end

    // Block decode, socket n uses codes 4n+1..4n+3
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            blk_common     <= 1'b0;
            blk_socket_reg <= 1'b0;
            blk_tx_buf     <= 1'b0;
            blk_rx_buf     <= 1'b0;
            blk_reserved   <= 1'b0;
            blk_socket     <= 3'h0;
        end
        else
        begin
            blk_common     <= (mem_block == `SPIF_BSB_COMMON);
            blk_socket_reg <= (mem_block[1:0] == `SPIF_SUB_REG);
            blk_tx_buf     <= (mem_block[1:0] == `SPIF_SUB_TXBUF);
            blk_rx_buf     <= (mem_block[1:0] == `SPIF_SUB_RXBUF);
            blk_reserved   <= (mem_block[1:0] == `SPIF_SUB_RSVD) && (mem_block != `SPIF_BSB_COMMON);
            blk_socket     <= mem_block[4:2];
        end
    end

    // Read data path: load one cycle after the fetch, shift on falling edges
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_dly_r      <= 1'b0;
            tx_sh_r       <= 8'h00;
            spi_miso_o    <= `SPIF_MISO_IDLE;
            spi_miso_oe_n <= 1'b1;
        end
        else
        begin
            rd_dly_r <= mem_rd;
            // Release the line when deselected so other slaves may share it
            spi_miso_oe_n <= cs_n_s;
            if (cs_n_s)
            begin
                tx_sh_r    <= 8'h00;
                spi_miso_o <= `SPIF_MISO_IDLE;
            end
            else if (rd_dly_r)
            begin
                tx_sh_r <= mem_rdata;
            end
            else if (sclk_fall)
            begin
                if (state_r == ST_DATA && rwb_r == `SPIF_RWB_READ)
                begin
                    spi_miso_o <= tx_sh_r[7];
                    tx_sh_r    <= {tx_sh_r[6:0], 1'b0};
                end
                else
                begin
                    spi_miso_o <= `SPIF_MISO_IDLE;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** src/spif_regs.vh ***
`ifndef SPIF_REGS_VH
`define SPIF_REGS_VH

// Control byte field positions
`define SPIF_BSB_HI        7
`define SPIF_BSB_LO        3
`define SPIF_RWB_BIT       2
`define SPIF_OM_HI         1
`define SPIF_OM_LO         0

// Read/write bit encoding
`define SPIF_RWB_READ      1'b0
`define SPIF_RWB_WRITE     1'b1

// Operation mode encodings
`define SPIF_OM_VAR        2'b00
`define SPIF_OM_FIX1       2'b01
`define SPIF_OM_FIX2       2'b10
`define SPIF_OM_FIX4       2'b11

// Fixed data lengths in bytes
`define SPIF_LEN_1         3'h1
`define SPIF_LEN_2         3'h2
`define SPIF_LEN_4         3'h4

// Block select: common block, and per-socket sub-block code in bits 1:0
`define SPIF_BSB_COMMON    5'h00
`define SPIF_SUB_RSVD      2'h0
`define SPIF_SUB_REG       2'h1
`define SPIF_SUB_TXBUF     2'h2
`define SPIF_SUB_RXBUF     2'h3

// Reset values
`define SPIF_ADDR_RST      16'h0000
`define SPIF_CTRL_RST      8'h00
`define SPIF_MISO_IDLE     1'b0

`endif

// *** src/spif_sync.v ***
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; only the second stage is visible outside
module spif_sync #(
    parameter             WIDTH   = 1,
    // Reset value of both stages; each bit should match its pin's idle level
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             nrst,
    // Asynchronous input and its synchronised copy
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_r   <= RST_VAL;
            sync_out <= RST_VAL;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

// *** test/spif_frame_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module spif_mon (
    // Clock, reset and pins
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       chip_select_n,
    input wire logic       spi_sclk,
    input wire logic       spi_miso_o,
    input wire logic       spi_miso_oe_n,
    // Store side and decode
    input wire logic [4:0] mem_block,
    input wire logic       mem_wr,
    input wire logic       mem_rd,
    input wire logic       blk_common,
    input wire logic       blk_reserved,
    input wire logic       blk_tx_buf,
    input wire logic       blk_socket_reg,
    input wire logic       blk_rx_buf,
    input wire logic [2:0] blk_socket,
    // Frame status
    input wire logic       frame_active,
    input wire logic       data_phase
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    property p_gap; (mem_wr || mem_rd) |=> !(mem_wr || mem_rd) [*8]; endproperty
    a_gap: assert property (p_gap) else $error("store strobe not a lone pulse");
    property p_wr_hi; mem_wr |-> spi_sclk && !chip_select_n && $past(data_phase); endproperty
    a_wr_hi: assert property (p_wr_hi) else $error("write not after a clock rise");
    property p_miso; !chip_select_n && $changed(spi_miso_o) |-> !spi_sclk; endproperty
    a_miso: assert property (p_miso) else $error("data out moved with clock high");
    property p_oe_on; !chip_select_n [*4] |-> !spi_miso_oe_n && frame_active; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data out not driven while selected");
    property p_oe_off; chip_select_n [*4] |-> spi_miso_oe_n && !frame_active; endproperty
    a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
    property p_com; $past(nrst) && $past(mem_block) == 5'h00 |-> blk_common; endproperty
    a_com: assert property (p_com) else $error("common block not flagged");
    property p_rsv; $past(nrst) |-> blk_reserved == ($past(mem_block[1:0]) == 2'h0 && $past(mem_block) != 5'h00);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
    property p_sock; $past(nrst) |-> blk_socket == $past(mem_block[4:2]) && blk_tx_buf == ($past(mem_block[1:0]) == 2'h2)
        && blk_socket_reg == ($past(mem_block[1:0]) == 2'h1) && blk_rx_buf == ($past(mem_block[1:0]) == 2'h3);
    endproperty
    a_sock: assert property (p_sock) else $error("socket decode wrong");
    c_rsv: cover property (mem_wr && blk_reserved);
    c_rd: cover property (mem_rd);
    c_out: cover property (!spi_miso_oe_n && spi_miso_o);
endmodule
bind spif_frame spif_mon u_mon (.clk_sys, .nrst, .chip_select_n, .spi_sclk, .spi_miso_o, .spi_miso_oe_n,
    .mem_block, .mem_wr, .mem_rd, .blk_common, .blk_reserved, .blk_tx_buf, .blk_socket_reg, .blk_rx_buf,
    .blk_socket, .frame_active, .data_phase);
`default_nettype wire

// *** test/spif_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module spif_host (
    // Host-driven pins
    output var logic  chip_select_n,
    output var logic  spi_sclk,
    output var logic  spi_mosi,
    // Line from the device
    input wire logic  spi_miso_o
);
    logic cpol = 1'b0;
    int   half = 400;
    initial
    begin
        chip_select_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b1;
    end
    task automatic mode(input logic p);
        cpol = p;
        spi_sclk = p;
    endtask
    task automatic sel;
        chip_select_n = 1'b0;
        #half;
    endtask
    task automatic desel;
        // Scramble so the device cannot lean on a stale level
        spi_mosi = ~spi_mosi;
        #half;
        chip_select_n = 1'b1;
        #(2 * half);
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            // Mode 3 rests high, so its first fall of a byte comes here
            if (spi_sclk)
                spi_sclk = 1'b0;
            spi_mosi = tx[i];
            #half;
            spi_sclk = 1'b1;
            rx[i] = spi_miso_o;
            #half;
        end
        if (!cpol)
            spi_sclk = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** test/tb_spif_frame.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_spif_frame;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  mem_rdata = 8'h00;
    logic [7:0]  rx;
    wire         chip_select_n, spi_sclk, spi_mosi, spi_miso_o, spi_miso_oe_n, mem_wr, mem_rd, fixed_length_mode;
    wire  [15:0] mem_addr;
    wire  [4:0]  mem_block;
    wire  [7:0]  mem_wdata;
    wire         miso_line = spi_miso_oe_n ? ~spi_miso_o : spi_miso_o;
    logic [28:0] wq[$];
    int          mismatches = 0;
    int          n_checks = 0;
    // Rows: offset, control byte, data bytes (also the expected write count)
    logic [31:0] rows [5] = '{32'h1234_0c_03, 32'hfffe_14_03, 32'h0040_1d_01, 32'h0080_06_02, 32'h00c0_2f_04};
    spif_frame uut (.clk_sys, .nrst, .chip_select_n, .spi_sclk, .spi_mosi, .spi_miso_o, .spi_miso_oe_n,
        .mem_addr, .mem_block, .mem_wr, .mem_wdata, .mem_rd, .mem_rdata, .blk_common(), .blk_socket_reg(),
        .blk_tx_buf(), .blk_rx_buf(), .blk_reserved(), .blk_socket(), .frame_active(), .data_phase(),
        .fixed_length_mode);
    spif_host host (.chip_select_n, .spi_sclk, .spi_mosi, .spi_miso_o(miso_line));
    always #50 clk_sys = ~clk_sys;
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    // Read data lives one cycle only, so late sampling shows up
    always @(posedge clk_sys)
    begin
        if (mem_wr === 1'b1)
            wq.push_back({mem_block, mem_addr, mem_wdata});
        mem_rdata <= #1 (mem_rd === 1'b1) ? pat(mem_addr) : ~mem_rdata;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            mismatches++;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic frame(input logic [15:0] o, input logic [7:0] c, input int n, input logic keep);
        wq.delete();
        if (chip_select_n === 1'b1)
            host.sel();
        host.xfer(o[15:8], rx);
        host.xfer(o[7:0], rx);
        host.xfer(c, rx);
        for (int k = 0; k < n; k++)
        begin
            host.xfer(o[7:0] ^ 8'h5a ^ k[7:0], rx);
            if (!c[2])
                chk("rdata", rx, pat(o + k[15:0]));
        end
        if (!keep)
            host.desel();
        repeat (4) @(posedge clk_sys);
        #1;
        chk("nwr", wq.size(), c[2] ? n : 0);
        foreach (wq[k])
            chk("wr", wq[k], {c[7:3], o + k[15:0], o[7:0] ^ 8'h5a ^ k[7:0]});
    endtask
    initial
    begin
        #5ms;
        mismatches++;
        tally_and_finish;
    end
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1 nrst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        foreach (rows[i])
        begin
            frame(rows[i][31:16], rows[i][15:8], rows[i][7:0], 1'b0);
            frame(rows[i][31:16], rows[i][15:8] & 8'hfb, rows[i][7:0], 1'b0);
            chk("fixed", fixed_length_mode, rows[i][9:8] != 2'h0);
            $display("row %0d done", i);
        end
        for (int b = 0; b < 32; b++)
            frame(16'h0100 + b[15:0], {b[4:0], 3'b100}, 1, 1'b0);
        $display("block codes done");
        frame(16'h0200, 8'h0e, 2, 1'b1);
        frame(16'h0200, 8'h09, 1, 1'b1);
        host.desel();
        $display("fixed back-to-back done");
        host.sel();
        host.xfer(8'h77, rx);
        host.desel();
        frame(16'h0345, 8'h0c, 2, 1'b0);
        $display("abort done");
        host.mode(1'b1);
        frame(16'h0abc, 8'h0c, 2, 1'b0);
        frame(16'h0abc, 8'h08, 2, 1'b0);
        host.mode(1'b0);
        $display("clock mode 3 done");
        host.sel();
        host.xfer(8'h12, rx);
        @(posedge clk_sys);
        #1 nrst = 1'b0;
        @(posedge clk_sys);
        #1 chk("oe_rst", spi_miso_oe_n, 1'b1);
        chk("addr_rst", mem_addr, 16'h0000);
        nrst = 1'b1;
        host.desel();
        frame(16'h0400, 8'h0c, 1, 1'b0);
        $display("reset mid-frame done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
